// ===== design/interrupt_vector_mapper.sv
// Interrupt flag, enable and vector mapping logic
`timescale 1ns/100ps
// Notes on behaviour
// - Flags set on their condition pulse whether or not the source is enabled.
// - Software write strobes load each source's enable bit; the written value is honoured.
// - A source other than the scan NMI requests only when both its flag and its enable are set; the NMI needs only its flag.
// - A request stays active until its flag is cleared or, except for the NMI, its enable bit or the global enable goes low (vector 9 also needs split).
// - Nothing but the scan NMI on vector 1 reaches the core while the global enable is low.
// - Each vector belongs to one peripheral; its sources are ORed onto it.
// - Vector 0 is reset at 0x00, vector 1 the scan NMI at 0x02; address 2n.
// - Vectors 2,3,4 carry level monitor, counter and periodic requests.
// - Vector 8 overflow or low underflow; vector 9 high underflow in split only.
// - Vectors 10 to 12 carry timer A compare 0 to 2, low half when split.
// - Vectors 14,15,16 carry two-wire client, two-wire host and serial interface.
// - USART0 on 17..19 and USART1 on 26..28: receive, empty, transmit.
// - Converter error 21, result 22, sample 23.
// - Port C on 24, timer B1 on 25, memory ready on 29.
// - Custom logic 5, ports A and B on 6 and 7, timer B0 13, comparator 20.
module interrupt_vector_mapper
  import ivm_pkg::*;
#(
  parameter int unsigned SOURCES = ivm_pkg::NUM_SRC
) (
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_clk_en,
  input  wire logic [ivm_pkg::NUM_SRC-1:0] i_flag_set,
  input  wire logic [ivm_pkg::NUM_SRC-1:0] i_flag_clear,
  input  wire logic                       i_enable_write,
  input  wire logic [ivm_pkg::NUM_SRC-1:0] i_enable_data,
  input  wire logic                       i_global_enable,
  input  wire logic                       i_timer_a_split,
  output logic [ivm_pkg::NUM_SRC-1:0]      o_interrupt_flag_register,
  output logic [ivm_pkg::NUM_SRC-1:0]      o_interrupt_enable_register,
  output logic                             o_irq_valid,
  output logic [ivm_pkg::VEC_W-1:0]        o_irq_vector,
  output logic [ivm_pkg::ADDR_W-1:0]       o_irq_address,
  output logic [ivm_pkg::NUM_VECTORS-1:0]  o_vector_pending
);
  import ivm_pkg::*;

  // ==========================================================
  // Parameter check
  // The source table is fixed, so any other width would misalign the map
  if (SOURCES != NUM_SRC) begin : g_bad_sources
    $error("SOURCES must equal the fixed source table size");
  end

  // ==========================================================
  // Flags and enables
  logic [NUM_SRC-1:0] flag;
  logic [NUM_SRC-1:0] next_flag;
  logic [NUM_SRC-1:0] enable;
  logic [NUM_SRC-1:0] next_enable;

  always_comb begin
    // Set beats a same-cycle clear so no event is lost
    next_flag = (flag & ~i_flag_clear) | i_flag_set;
    next_enable = i_enable_write ? i_enable_data : enable;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag   <= FLAG_RESET;
      enable <= ENABLE_RESET;
    end else if (i_clk_en) begin
      flag   <= next_flag;
      enable <= next_enable;
    end
  end

  // ==========================================================
  // Vector mapping
  function automatic logic [ADDR_W-1:0] word_address(input logic [VEC_W-1:0] v);
    word_address = {v, 1'b0};
  endfunction

  logic [NUM_SRC-1:0]     req;
  logic [NUM_VECTORS-1:0] vec_req;
  logic                   split;

  always_comb begin
    split = i_timer_a_split;
    req   = flag & enable;
    vec_req = '0;
    vec_req[VEC_RESET] = 1'b0;
    // Non-maskable: bypasses the global enable but still needs its flag
    vec_req[VEC_NMI]     = flag[SRC_NMI];
    vec_req[VEC_VLM]     = req[SRC_VLM];
    vec_req[VEC_RTC_COUNTER]  = req[SRC_RTC_OVF] | req[SRC_RTC_CMP];
    vec_req[VEC_RTC_PERIODIC] = req[SRC_RTC_PERIODIC];
    vec_req[VEC_CCL]     = req[SRC_CCL];
    vec_req[VEC_PORTA]   = req[SRC_PORTA];
    vec_req[VEC_PORTB]   = req[SRC_PORTB];
    vec_req[VEC_TA_OVF]  = req[SRC_TA_OVF];
    vec_req[VEC_TA_HUNF] = split & req[SRC_TA_HUNF];
    for (int i = 0; i < CHANNELS_PER_GROUP; i++) begin
      vec_req[int'(VEC_TA_CMP0) + i] = req[SRC_TA_CMP0 + i];
    end
    vec_req[VEC_TB0]     = req[SRC_TB0];
    vec_req[VEC_TWI_C]   = req[SRC_TWI_C];
    vec_req[VEC_TWI_H]   = req[SRC_TWI_H];
    vec_req[VEC_SPI]     = req[SRC_SPI];
    vec_req[VEC_AC]      = req[SRC_AC];
    for (int i = 0; i < CHANNELS_PER_GROUP; i++) begin
      vec_req[int'(VEC_U0_RXC) + i]  = req[SRC_U0_RXC + i];
      vec_req[int'(VEC_ADC_ERR) + i] = req[SRC_ADC_ERR + i];
      vec_req[int'(VEC_U1_RXC) + i]  = req[SRC_U1_RXC + i];
    end
    vec_req[VEC_PORTC]   = req[SRC_PORTC];
    vec_req[VEC_TB1]     = req[SRC_TB1];
    vec_req[VEC_NVM]     = req[SRC_NVM];
    // Global gate on every maskable vector
    if (!i_global_enable) begin
      vec_req[NUM_VECTORS-1:int'(VEC_VLM)] = '0;
    end
  end

  // ==========================================================
  // Priority pick
  logic                   next_valid;
  logic [VEC_W-1:0]       next_vector;
  logic [ADDR_W-1:0]      next_address;

  always_comb begin
    next_valid  = 1'b0;
    next_vector = VEC_RESET;
    for (int i = NUM_VECTORS - 1; i >= 0; i--) begin
      if (vec_req[i]) begin
        next_valid  = 1'b1;
        next_vector = VEC_W'(i);
      end
    end
    next_address = word_address(next_vector);
  end

  // Outputs registered: one cycle latency from flag to core
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq_valid                 <= 1'b0;
      o_irq_vector                <= VEC_RESET;
      o_irq_address               <= '0;
      o_vector_pending            <= '0;
      o_interrupt_flag_register   <= FLAG_RESET;
      o_interrupt_enable_register <= ENABLE_RESET;
    end else if (i_clk_en) begin
      o_irq_valid                 <= next_valid;
      o_irq_vector                <= next_vector;
      o_irq_address               <= next_address;
      o_vector_pending            <= vec_req;
      o_interrupt_flag_register   <= next_flag;
      o_interrupt_enable_register <= next_enable;
    end
  end

  // ==========================================================
  // Checks
  property p_flag_set_unconditional;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_clk_en && i_flag_set[SRC_VLM]) |=> flag[SRC_VLM];
  endproperty
  a_flag_set_unconditional: assert property (p_flag_set_unconditional)
    else $error("flag not set by condition");

  property p_enable_written;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_clk_en && i_enable_write) |=> enable == $past(i_enable_data);
  endproperty
  a_enable_written: assert property (p_enable_written)
    else $error("enable not loaded");

  property p_no_req_without_enable;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_clk_en && (!enable[SRC_SPI] || !flag[SRC_SPI])) |=> !o_vector_pending[VEC_SPI];
  endproperty
  a_no_req_without_enable: assert property (p_no_req_without_enable)
    else $error("spi request without flag and enable");

  property p_req_holds;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_clk_en && vec_req[VEC_PORTA] && !i_flag_clear[SRC_PORTA]
       && !i_enable_write && i_global_enable) ##1 i_global_enable |-> vec_req[VEC_PORTA];
  endproperty
  a_req_holds: assert property (p_req_holds)
    else $error("request dropped without clear");

  property p_global_gate;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_clk_en && !i_global_enable && !flag[SRC_NMI]) |=> !o_irq_valid;
  endproperty
  a_global_gate: assert property (p_global_gate)
    else $error("request passed with global enable low");

  property p_address_twice;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      o_irq_address == {o_irq_vector, 1'b0};
  endproperty
  a_address_twice: assert property (p_address_twice)
    else $error("vector address is not twice the number");

  property p_hunf_split_only;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !i_timer_a_split |-> !vec_req[VEC_TA_HUNF];
  endproperty
  a_hunf_split_only: assert property (p_hunf_split_only)
    else $error("high underflow vector outside split mode");

  property p_lowest_first;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_clk_en && vec_req[VEC_VLM]) |=> o_irq_valid && o_irq_vector <= VEC_VLM;
  endproperty
  a_lowest_first: assert property (p_lowest_first)
    else $error("lower vector not presented first");

  property p_nvm_map;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_global_enable && req[SRC_NVM]) |-> vec_req[VEC_NVM];
  endproperty
  a_nvm_map: assert property (p_nvm_map)
    else $error("memory ready not on its vector");

  property p_set_beats_clear;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_clk_en && i_flag_set[SRC_SPI] && i_flag_clear[SRC_SPI]) |=> flag[SRC_SPI];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("clear won over a same-cycle set");

  property p_clear_drops;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_clk_en && i_flag_clear[SRC_NVM] && !i_flag_set[SRC_NVM]) |=> !flag[SRC_NVM];
  endproperty
  a_clear_drops: assert property (p_clear_drops)
    else $error("flag survived its clear");

  property p_nmi_first;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_clk_en && flag[SRC_NMI]) |=> o_irq_valid && o_irq_vector == VEC_NMI;
  endproperty
  a_nmi_first: assert property (p_nmi_first)
    else $error("scan checker vector not presented");

  property p_reset_vector_idle;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      o_irq_valid |-> o_irq_vector != VEC_RESET;
  endproperty
  a_reset_vector_idle: assert property (p_reset_vector_idle)
    else $error("reset vector presented as a request");

  property p_rtc_shared;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_clk_en && i_global_enable && (req[SRC_RTC_OVF] || req[SRC_RTC_CMP]))
      |=> o_vector_pending[VEC_RTC_COUNTER];
  endproperty
  a_rtc_shared: assert property (p_rtc_shared)
    else $error("counter sources not on their shared vector");

  property p_periodic_map;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_clk_en && i_global_enable && req[SRC_RTC_PERIODIC]) |=> o_vector_pending[VEC_RTC_PERIODIC];
  endproperty
  a_periodic_map: assert property (p_periodic_map)
    else $error("periodic request not on its vector");

  property p_cmp_map;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_clk_en && i_global_enable && req[SRC_TA_CMP0 + CHANNELS_PER_GROUP - 1])
      |=> o_vector_pending[int'(VEC_TA_CMP0) + CHANNELS_PER_GROUP - 1];
  endproperty
  a_cmp_map: assert property (p_cmp_map)
    else $error("last compare channel not on its vector");

  property p_spi_map;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_clk_en && i_global_enable && req[SRC_SPI]) |=> o_vector_pending[VEC_SPI];
  endproperty
  a_spi_map: assert property (p_spi_map)
    else $error("serial interface request not on its vector");

  property p_usart_map;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_clk_en && i_global_enable && req[SRC_U1_RXC + CHANNELS_PER_GROUP - 1])
      |=> o_vector_pending[int'(VEC_U1_RXC) + CHANNELS_PER_GROUP - 1];
  endproperty
  a_usart_map: assert property (p_usart_map)
    else $error("second usart transmit not on its vector");

  property p_adc_map;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_clk_en && i_global_enable && req[SRC_ADC_ERR + CHANNELS_PER_GROUP - 1])
      |=> o_vector_pending[int'(VEC_ADC_ERR) + CHANNELS_PER_GROUP - 1];
  endproperty
  a_adc_map: assert property (p_adc_map)
    else $error("converter sample request not on its vector");

  property p_port_map;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_clk_en && i_global_enable && req[SRC_PORTB]) |=> o_vector_pending[VEC_PORTB];
  endproperty
  a_port_map: assert property (p_port_map)
    else $error("port B request not on its vector");

  c_irq_raised: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(o_irq_valid));
  c_nmi_masked: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_irq_valid && o_irq_vector == VEC_NMI && !i_global_enable);
  c_two_pending: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    vec_req[VEC_SPI] && vec_req[VEC_NVM]);
  c_split_hunf: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_irq_vector == VEC_TA_HUNF && o_irq_valid);

endmodule // interrupt_vector_mapper

// ===== shared/ivm_pkg.sv
// Constants for the interrupt vector mapper
package ivm_pkg;
  localparam int unsigned NUM_VECTORS = 30;
  localparam int unsigned VEC_W       = 5;
  localparam int unsigned ADDR_W      = 6;
  localparam int unsigned NUM_SRC     = 31;
  // Timer compare, USART and converter sources come in groups of three
  localparam int unsigned CHANNELS_PER_GROUP = 3;
  // Vector numbers
  localparam logic [4:0] VEC_RESET    = 5'h00;
  localparam logic [4:0] VEC_NMI      = 5'h01;
  localparam logic [4:0] VEC_VLM      = 5'h02;
  localparam logic [4:0] VEC_RTC_COUNTER  = 5'h03;
  localparam logic [4:0] VEC_RTC_PERIODIC = 5'h04;
  localparam logic [4:0] VEC_CCL      = 5'h05;
  localparam logic [4:0] VEC_PORTA    = 5'h06;
  localparam logic [4:0] VEC_PORTB    = 5'h07;
  localparam logic [4:0] VEC_TA_OVF   = 5'h08;
  localparam logic [4:0] VEC_TA_HUNF  = 5'h09;
  localparam logic [4:0] VEC_TA_CMP0  = 5'h0a;
  localparam logic [4:0] VEC_TB0      = 5'h0d;
  localparam logic [4:0] VEC_TWI_C    = 5'h0e;
  localparam logic [4:0] VEC_TWI_H    = 5'h0f;
  localparam logic [4:0] VEC_SPI      = 5'h10;
  localparam logic [4:0] VEC_U0_RXC   = 5'h11;
  localparam logic [4:0] VEC_AC       = 5'h14;
  localparam logic [4:0] VEC_ADC_ERR  = 5'h15;
  localparam logic [4:0] VEC_PORTC    = 5'h18;
  localparam logic [4:0] VEC_TB1      = 5'h19;
  localparam logic [4:0] VEC_U1_RXC   = 5'h1a;
  localparam logic [4:0] VEC_NVM      = 5'h1d;
  // Source index layout: 31 sources, one flag and one enable each
  localparam int unsigned SRC_VLM      = 0;
  localparam int unsigned SRC_RTC_OVF  = 1;
  localparam int unsigned SRC_RTC_CMP  = 2;
  localparam int unsigned SRC_RTC_PERIODIC = 3;
  localparam int unsigned SRC_CCL      = 4;
  localparam int unsigned SRC_PORTA    = 5;
  localparam int unsigned SRC_PORTB    = 6;
  localparam int unsigned SRC_TA_OVF   = 7;
  localparam int unsigned SRC_TA_HUNF  = 8;
  localparam int unsigned SRC_TA_CMP0  = 9;
  localparam int unsigned SRC_TB0      = 12;
  localparam int unsigned SRC_TWI_C    = 13;
  localparam int unsigned SRC_TWI_H    = 14;
  localparam int unsigned SRC_SPI      = 15;
  localparam int unsigned SRC_U0_RXC   = 16;
  localparam int unsigned SRC_AC       = 19;
  localparam int unsigned SRC_ADC_ERR  = 20;
  localparam int unsigned SRC_PORTC    = 23;
  localparam int unsigned SRC_TB1      = 24;
  localparam int unsigned SRC_U1_RXC   = 25;
  localparam int unsigned SRC_NVM      = 28;
  localparam int unsigned SRC_NMI      = 29;
  localparam int unsigned SRC_SPARE    = 30;
  localparam logic [30:0] FLAG_RESET   = 31'h0000_0000;
  localparam logic [30:0] ENABLE_RESET = 31'h0000_0000;
endpackage

// ===== verification/test_interrupt_vector_mapper.sv
// Self-checking testbench for the interrupt vector mapper
`timescale 1ns/100ps
module test_interrupt_vector_mapper;
  import ivm_pkg::*;
  logic                   i_sys_clk;
  logic                   i_rst_n;
  logic                   i_clk_en;
  logic [NUM_SRC-1:0]     i_flag_set;
  logic [NUM_SRC-1:0]     i_flag_clear;
  logic                   i_enable_write;
  logic [NUM_SRC-1:0]     i_enable_data;
  logic                   i_global_enable;
  logic                   i_timer_a_split;
  logic [NUM_SRC-1:0]     flag_reg;
  logic [NUM_SRC-1:0]     enable_reg;
  logic                   irq_valid;
  logic [VEC_W-1:0]       irq_vector;
  logic [ADDR_W-1:0]      irq_address;
  logic [NUM_VECTORS-1:0] vector_pending;
  logic [VEC_W-1:0]       fetched_vector;
  logic [ADDR_W-1:0]      fetched_address;
  int                     err_count = 0;
  int                     tests_run = 0;
  int                     cycles = 0;
  logic [4:0]             v;

  interrupt_vector_mapper i_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
    .i_flag_set(i_flag_set), .i_flag_clear(i_flag_clear), .i_enable_write(i_enable_write),
    .i_enable_data(i_enable_data), .i_global_enable(i_global_enable),
    .i_timer_a_split(i_timer_a_split), .o_interrupt_flag_register(flag_reg),
    .o_interrupt_enable_register(enable_reg), .o_irq_valid(irq_valid),
    .o_irq_vector(irq_vector), .o_irq_address(irq_address), .o_vector_pending(vector_pending));
  vector_fetch_model i_core (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_irq_valid(irq_valid),
    .i_irq_vector(irq_vector), .i_irq_address(irq_address),
    .o_fetched_vector(fetched_vector), .o_fetched_address(fetched_address));

  // ==========================================
  // Clock, timeout and shared tasks
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // The whole run needs about 300 cycles; over six times that can only be a hang
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report();
    if (err_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [NUM_SRC-1:0] bit_of(input int s);
    logic [NUM_SRC-1:0] m;
    m = '0;
    m[s] = 1'b1;
    return m;
  endfunction
  // Vector expected for each source index of the mapper up to the scan NMI; the spare source has none
  function automatic logic [4:0] exp_vec(input int s);
    if (s == SRC_NMI) return VEC_NMI;
    if (s == SRC_VLM) return VEC_VLM;
    if (s <= SRC_RTC_CMP) return VEC_RTC_COUNTER;
    return 5'(s + 1);
  endfunction
  // Flag pulses take one edge, the request one more edge
  task automatic pulse(input logic [NUM_SRC-1:0] set_m, input logic [NUM_SRC-1:0] clr_m);
    @(posedge i_sys_clk) #1;
    i_flag_set = set_m;
    i_flag_clear = clr_m;
    @(posedge i_sys_clk) #1;
    i_flag_set = '0;
    i_flag_clear = '0;
    @(posedge i_sys_clk) #1;
  endtask
  task automatic write_enables(input logic [NUM_SRC-1:0] data);
    @(posedge i_sys_clk) #1;
    i_enable_write = 1'b1;
    i_enable_data = data;
    @(posedge i_sys_clk) #1;
    i_enable_write = 1'b0;
    @(posedge i_sys_clk) #1;
  endtask

  // ==========================================
  // Test sequence
  initial begin
    i_rst_n = 1'b0;
    i_clk_en = 1'b1;
    i_flag_set = '0;
    i_flag_clear = '0;
    i_enable_write = 1'b0;
    i_enable_data = '0;
    i_global_enable = 1'b1;
    i_timer_a_split = 1'b1;
    repeat (12) @(posedge i_sys_clk);
    #1 i_rst_n = 1'b1;
    check("enables after reset", enable_reg, 64'h0);
    check("valid after reset", irq_valid, 64'h0);
    pulse(bit_of(SRC_SPI), '0);
    check("flag while disabled", flag_reg, bit_of(SRC_SPI));
    check("valid while disabled", irq_valid, 64'h0);
    write_enables(bit_of(SRC_SPI));
    check("enable register", enable_reg, bit_of(SRC_SPI));
    check("spi vector", irq_vector, VEC_SPI);
    pulse('0, bit_of(SRC_SPI));
    check("valid after clear", irq_valid, 64'h0);
    write_enables('1);
    check("all enables", enable_reg, {NUM_SRC{1'b1}});
    for (int s = 0; s <= SRC_NMI; s++) begin
      v = exp_vec(s);
      pulse(bit_of(s), '0);
      check("vector", irq_vector, v);
      check("address", irq_address, {v, 1'b0});
      check("pending", vector_pending, 64'h1 << v);
      @(posedge i_sys_clk) #1;
      check("core fetch address", fetched_address, {v, 1'b0});
      check("core fetch vector", fetched_vector, v);
      pulse('0, bit_of(s));
      check("valid after clear", irq_valid, 64'h0);
    end
    pulse(bit_of(SRC_AC), '0);
    repeat (20) @(posedge i_sys_clk);
    #1 check("held request", irq_vector, VEC_AC);
    pulse(bit_of(SRC_PORTA), '0);
    check("lowest first", irq_vector, VEC_PORTA);
    pulse('0, bit_of(SRC_PORTA));
    check("next pending", irq_vector, VEC_AC);
    i_global_enable = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1 check("global off", irq_valid, 64'h0);
    pulse(bit_of(SRC_NMI), '0);
    check("nmi unmasked", irq_vector, VEC_NMI);
    pulse('0, bit_of(SRC_NMI) | bit_of(SRC_AC));
    i_global_enable = 1'b1;
    i_timer_a_split = 1'b0;
    pulse(bit_of(SRC_TA_HUNF), '0);
    check("high underflow unsplit", irq_valid, 64'h0);
    i_timer_a_split = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1 check("high underflow split", irq_vector, VEC_TA_HUNF);
    pulse(bit_of(SRC_RTC_OVF) | bit_of(SRC_RTC_CMP), bit_of(SRC_TA_HUNF));
    pulse('0, bit_of(SRC_RTC_OVF));
    check("shared vector", irq_vector, VEC_RTC_COUNTER);
    pulse('0, bit_of(SRC_RTC_CMP));
    check("shared cleared", irq_valid, 64'h0);
    pulse(bit_of(SRC_SPI) | bit_of(SRC_NVM), '0);
    check("spi before memory", irq_vector, VEC_SPI);
    write_enables(~bit_of(SRC_SPI));
    check("spi disabled", irq_vector, VEC_NVM);
    check("flag kept while disabled", flag_reg, bit_of(SRC_SPI) | bit_of(SRC_NVM));
    write_enables('1);
    pulse(bit_of(SRC_SPI), bit_of(SRC_SPI) | bit_of(SRC_NVM));
    check("set beats clear", flag_reg, bit_of(SRC_SPI));
    check("spi after memory clear", irq_vector, VEC_SPI);
    pulse('0, bit_of(SRC_SPI));
    check("all cleared", irq_valid, 64'h0);
    i_clk_en = 1'b0;
    pulse(bit_of(SRC_VLM), '0);
    check("frozen flags", flag_reg, 64'h0);
    i_clk_en = 1'b1;
    final_report();
  end
endmodule // test_interrupt_vector_mapper

// ===== verification/vector_fetch_model.sv
// Processor core model that fetches the presented interrupt vector
`timescale 1ns/100ps
module vector_fetch_model
  import ivm_pkg::*;
#(
  parameter int unsigned LATENCY = 1
) (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_irq_valid,
  input  wire logic [VEC_W-1:0]      i_irq_vector,
  input  wire logic [ADDR_W-1:0]     i_irq_address,
  output logic      [VEC_W-1:0]      o_fetched_vector,
  output logic      [ADDR_W-1:0]     o_fetched_address
);
  // ==========================================
  // Fetch after a fixed response delay
  int unsigned wait_cnt;
  // A core only fetches a request that is still standing after its latency
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_cnt          <= 0;
      o_fetched_vector  <= 5'h00;
      o_fetched_address <= 6'h00;
    end else if (!i_irq_valid) begin
      wait_cnt <= 0;
    end else begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt == LATENCY - 1) begin
        o_fetched_vector  <= i_irq_vector;
        o_fetched_address <= i_irq_address;
      end
    end
  end
endmodule // vector_fetch_model
